// [dmp_pkg.sv]
package dmp_pkg;

  // state encoding of the three state bits {a,b,c}, L=0 H=1
  localparam logic [2:0] ST_LHH = 3'h3;
  localparam logic [2:0] ST_LLH = 3'h1;
  localparam logic [2:0] ST_LLL = 3'h0;
  localparam logic [2:0] ST_HLL = 3'h4;
  localparam logic [2:0] ST_HHL = 3'h6;
  localparam logic [2:0] ST_HHH = 3'h7;
  localparam logic [2:0] ST_RESET = ST_LHH;

  localparam int unsigned RATIO_LOW  = 5;
  localparam int unsigned RATIO_HIGH = 6;

  // documented ceiling of the input clock, in MHz
  localparam int unsigned MAX_CLOCK_MHZ = 300;

endpackage

// [dmp_sync.sv]
module dmp_sync
  import dmp_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage is read by the second stage only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [dmp_prescaler.sv]
// Summary of operation
// - divide by 5 unless both selects low
// - step LHH LLH LLL HLL HHL, plus HHH
// - true and inverse outputs, one rise and one fall per division cycle
// - counts correctly in both ratios at speed
module dmp_prescaler
  import dmp_pkg::*;
(
  // clock and reset
  input  wire logic MCLK_IN,
  input  wire logic RESET_IN,
  // ratio select, active low
  input  wire logic RATIO_SELECT_N_A_IN,
  input  wire logic RATIO_SELECT_N_B_IN,
  // divided outputs
  output logic      DIV_TRUE_OUT,
  output logic      DIV_INV_OUT,
  output logic      STATE_BIT_A_OUT,
  output logic      STATE_BIT_B_OUT,
  output logic      STATE_BIT_C_OUT
);

  logic [1:0] sel_sync;
  logic       six_req;
  logic [2:0] state_q;
  logic [2:0] state_d;

  // selects come from off-chip logic, so they are synchronised first
  dmp_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_in   (MCLK_IN),
    .rst_in   (RESET_IN),
    .async_in ({RATIO_SELECT_N_A_IN, RATIO_SELECT_N_B_IN}),
    .sync_out (sel_sync)
  );

  assign six_req = (sel_sync == 2'h0);

  // decision taken only at HHL; other states ignore the selects
  always_comb begin
    case (state_q)
      ST_LHH:  state_d = ST_LLH;
      ST_LLH:  state_d = ST_LLL;
      ST_LLL:  state_d = ST_HLL;
      ST_HLL:  state_d = ST_HHL;
      ST_HHL:  state_d = six_req ? ST_HHH : ST_LHH;
      ST_HHH:  state_d = ST_LHH;
      // lockout recovery for unused codes 2 and 5
      default: state_d = ST_LHH;
    endcase
  end

  // plain synchronous counter, one state per clock keeps timing trivial
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // output taken from bit a: low for 3 states, high for 2 or 3
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      DIV_TRUE_OUT <= 1'b0;
      DIV_INV_OUT  <= 1'b1;
    end else begin
      DIV_TRUE_OUT <= state_d[2];
      DIV_INV_OUT  <= ~state_d[2];
    end
  end

  assign STATE_BIT_A_OUT = state_q[2];
  assign STATE_BIT_B_OUT = state_q[1];
  assign STATE_BIT_C_OUT = state_q[0];

  // helper: cycles since entering LHH
  logic [2:0] cyc_q;
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      cyc_q <= 3'h0;
    end else if (state_d == ST_LHH) begin
      cyc_q <= 3'h0;
    end else begin
      cyc_q <= cyc_q + 3'h1;
    end
  end

  sequence s_five_walk;
    state_q == ST_LHH ##1 state_q == ST_LLH ##1 state_q == ST_LLL ##1 state_q == ST_HLL ##1 state_q == ST_HHL;
  endsequence

  a_seq_steps: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    state_q == ST_LHH |-> ##1 state_q == ST_LLH ##1 state_q == ST_LLL ##1 state_q == ST_HLL ##1 state_q == ST_HHL)
    else $error("count sequence broken");

  // the select is judged where the walk ends, in HHL, not where it starts
  a_div_five: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (s_five_walk ##0 !six_req) |=> state_q == ST_LHH)
    else $error("divide by five missed");

  a_div_six: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (state_q == ST_HHL && six_req) |=> state_q == ST_HHH ##1 state_q == ST_LHH)
    else $error("extra state missing");

  a_cycle_len: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    cyc_q <= 3'(RATIO_HIGH - 1))
    else $error("division cycle too long");

  a_out_compl: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    DIV_TRUE_OUT == ~DIV_INV_OUT)
    else $error("outputs not complementary");

  a_out_tracks: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    DIV_TRUE_OUT == state_q[2])
    else $error("true output off state");

  a_out_rise: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    $rose(DIV_TRUE_OUT) |-> $past(state_q) == ST_LLL)
    else $error("output rose at wrong state");

  a_no_illegal: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    state_q != 3'h2 && state_q != 3'h5)
    else $error("illegal state code");

  // longest stretch of either output level within one division cycle
  localparam logic [2:0] HIGH_RUN_MAX = 3'(RATIO_HIGH - 3);
  localparam logic [2:0] LOW_RUN_MAX  = 3'(RATIO_LOW - 2);

  // helper: consecutive cycles with the true output high
  logic [2:0] high_run_q;
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      high_run_q <= 3'h0;
    end else if (DIV_TRUE_OUT) begin
      high_run_q <= high_run_q + 3'h1;
    end else begin
      high_run_q <= 3'h0;
    end
  end

  // helper: consecutive cycles with the true output low
  logic [2:0] low_run_q;
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      low_run_q <= 3'h0;
    end else if (!DIV_TRUE_OUT) begin
      low_run_q <= low_run_q + 3'h1;
    end else begin
      low_run_q <= 3'h0;
    end
  end

  // six-state walk: the five-state walk plus the inserted state
  sequence s_six_walk;
    s_five_walk ##1 state_q == ST_HHH;
  endsequence

  // tail of a cycle in which the controller asked for six
  sequence s_extra_tail;
    state_q == ST_HHL ##1 state_q == ST_HHH ##1 state_q == ST_LHH;
  endsequence

  a_six_return: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    s_six_walk |=> state_q == ST_LHH)
    else $error("six walk did not return");

  a_six_tail: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (state_q == ST_HHL && six_req) |-> s_extra_tail)
    else $error("extra state tail broken");

  // selects seen outside HHL must never produce the extra state
  a_sel_ignored: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (state_q != ST_HHL) |=> state_q != ST_HHH)
    else $error("extra state outside decision");

  a_inv_tracks: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    DIV_INV_OUT == ~state_q[2])
    else $error("inverse output off state");

  a_out_fall: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    $fell(DIV_TRUE_OUT) |-> state_q == ST_LHH)
    else $error("output fell at wrong state");

  a_high_run: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    high_run_q <= HIGH_RUN_MAX)
    else $error("true output high too long");

  a_low_run: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    low_run_q <= LOW_RUN_MAX)
    else $error("true output low too long");

  // reset is checked without the disable so the held state is seen
  a_reset_state: assert property (@(posedge MCLK_IN)
    $past(RESET_IN) |-> (state_q == ST_RESET && !DIV_TRUE_OUT && DIV_INV_OUT))
    else $error("reset state wrong");

  a_bits_ports: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    {STATE_BIT_A_OUT, STATE_BIT_B_OUT, STATE_BIT_C_OUT} == state_q)
    else $error("state bit ports differ");

endmodule

// [dmp_ctr_model.sv]
module dmp_ctr_model
  import dmp_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       inv_in,
  output logic            sel_a_n_out,
  output logic            sel_b_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock of loop delay, well inside the settle budget
  always_ff @(posedge clk_in) begin
    sel_a_n_out <= (mode_in == 2'h3) ? inv_in : mode_in[0];
    sel_b_n_out <= mode_in[1] & ~mode_in[0];
  end
endmodule

// [tb_dmp_prescaler.sv]
module tb_dmp_prescaler
  import dmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic       sa, sb, tru, inv;
  logic [2:0] st;
  int         fail_count = 0;
  int         n_tests = 0;
  int         cyc = 0;
  dmp_prescaler u_dut (.MCLK_IN(clk), .RESET_IN(rst), .RATIO_SELECT_N_A_IN(sa), .RATIO_SELECT_N_B_IN(sb),
    .DIV_TRUE_OUT(tru), .DIV_INV_OUT(inv), .STATE_BIT_A_OUT(st[2]), .STATE_BIT_B_OUT(st[1]),
    .STATE_BIT_C_OUT(st[0]));
  dmp_ctr_model u_ctr (.clk_in(clk), .mode_in(mode), .inv_in(inv), .sel_a_n_out(sa), .sel_b_n_out(sb));
  initial forever #50 clk = ~clk;
  task automatic finish_test();
    $display("tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // cycles between rising edges of the true output
  task automatic period(input logic [1:0] m, input logic [7:0] e);
    int n;
    logic p;
    logic r;
    @(posedge clk) mode <= m;
    repeat (20) @(posedge clk);
    @(posedge tru);
    n = 0;
    p = 1'b1;
    do begin
      @(posedge clk);
      #1;
      n++;
      chk({7'h0, inv}, {7'h0, ~tru});
      r = tru & ~p;
      p = tru;
    end while (!r && n < 20);
    chk(n[7:0], e);
    $display("period mode %0d done", m);
  endtask
  task automatic seq6();
    logic [2:0] ex [6] = '{ST_HLL, ST_HHL, ST_HHH, ST_LHH, ST_LLH, ST_LLL};
    @(posedge clk) mode <= 2'h0;
    repeat (20) @(posedge clk);
    @(posedge st[2]);
    #1;
    foreach (ex[i]) begin
      chk({5'h0, st}, {5'h0, ex[i]});
      @(posedge clk);
      #1;
    end
    $display("sequence done");
  endtask
  task automatic seq5();
    logic [2:0] ex [5] = '{ST_HLL, ST_HHL, ST_LHH, ST_LLH, ST_LLL};
    @(posedge clk) mode <= 2'h1;
    repeat (20) @(posedge clk);
    @(posedge st[2]);
    #1;
    foreach (ex[i]) begin
      chk({5'h0, st}, {5'h0, ex[i]});
      @(posedge clk);
      #1;
    end
    $display("sequence five done");
  endtask
  task automatic mid_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({5'h0, st}, {5'h0, ST_RESET});
    chk({6'h0, tru, inv}, 8'h01);
    @(posedge clk) rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({5'h0, st}, {5'h0, ST_LLH});
    $display("mid reset done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk({5'h0, st}, {5'h0, ST_RESET});
    @(posedge clk) rst <= 1'b0;
    period(2'h0, 8'h06);
    period(2'h1, 8'h05);
    period(2'h2, 8'h05);
    period(2'h3, 8'h05);
    period(2'h0, 8'h06);
    seq6();
    seq5();
    mid_reset();
    period(2'h3, 8'h05);
    finish_test();
  end
endmodule
